// [rtl/alarm_pkg.sv]
// shared constants, register map and types of the drive alarm monitor
package alarm_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_OVL_LIM   = 8'h04;
    localparam logic [7:0] OFS_DEV_ON    = 8'h08;
    localparam logic [7:0] OFS_DEV_OFF   = 8'h0c;
    localparam logic [7:0] OFS_COM_TMO   = 8'h10;
    localparam logic [7:0] OFS_COM_ERR   = 8'h14;
    localparam logic [7:0] OFS_ALARM     = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [8:0]  OVL_LIM_RST  = 9'h032;
    localparam logic [14:0] DEV_ON_RST   = 15'h012c;
    localparam logic [14:0] DEV_OFF_RST  = 15'h2710;
    localparam logic [13:0] COM_TMO_RST  = 14'h0000;
    localparam logic [3:0]  COM_ERR_RST  = 4'h3;
    // ----------------------------------------------------------------
    // timing: 0.1 s overload unit, 1 ms timeout unit at 50 MHz
    // ----------------------------------------------------------------
    localparam int CLK_HZ        = 50000000;
    localparam int OVL_UNIT_MS   = 100;
    localparam int TMO_UNIT_MS   = 1;
    localparam int OVL_UNIT_CYC  = CLK_HZ / 1000 * OVL_UNIT_MS;
    localparam int TMO_UNIT_CYC  = CLK_HZ / 1000 * TMO_UNIT_MS;
    // ----------------------------------------------------------------
    // alarm cause bits
    // ----------------------------------------------------------------
    localparam int NCAUSE    = 6;
    localparam int C_OVL     = 0;
    localparam int C_DEV_ON  = 1;
    localparam int C_DEV_OFF = 2;
    localparam int C_HOME    = 3;
    localparam int C_TMO     = 4;
    localparam int C_COMERR  = 5;
    localparam int BLINK_CYC = 12500000;

    typedef enum logic [1:0] {AHB_IDLE, AHB_WRITE, AHB_READ} ahb_phase_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
    } ahb_addr_type;
endpackage : alarm_pkg

// [rtl/input_sync.sv]
// three-stage pin synchroniser that accepts a change when stages agree
`timescale 1ns/1ps
module input_sync
    import alarm_pkg::*;
(
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // pin and clean level
    input  wire logic pin,
    output logic      level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sync_state_type;

    sync_state_type st;
    sync_state_type next_st;

    always_comb begin
        next_st     = st;
        next_st.s1  = pin;
        next_st.s2  = st.s1;
        next_st.s3  = st.s2;
        // stage one feeds stage two only
        if (st.s2 == st.s3) begin
            next_st.lvl = st.s3;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.lvl;
endmodule : input_sync

// [rtl/drive_alarm_monitor.sv]
// alarm detection, latching and alarm outputs of a stepping-motor driver
// How it works
// - direct fault output conducts unless alarm
// - remote fault bit high on alarm
// - alarm blinks lamp and cuts current
// - overload longer than limit raises alarm
// - deviation over on-limit with current on
// - separate current-off deviation limit held
// - current off, over on-limit gives warning
// - excitation on during off-deviation raises alarm
// - home-incomplete alarm only when enabled
// - link timeout monitored, zero disables
// - error count reaching setting raises alarm
// - falling edge of clear input resets
// - excitation input decides energised state
`timescale 1ns/1ps
module drive_alarm_monitor
    import alarm_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // motor status from the drive core
    input  wire logic        overload,
    input  wire logic [15:0] deviation,
    input  wire logic        op_start,
    input  wire logic        origin_set,
    // serial link events
    input  wire logic        frame_ok,
    input  wire logic        frame_err,
    // pins from the host
    input  wire logic        excite_pin,
    input  wire logic        fault_clear_input,
    // outputs
    output logic             fault_indicator_output,
    output logic             fault_remote_bit,
    output logic             alarm_lamp,
    output logic             motor_current_on,
    output logic             motor_stop,
    output logic             dev_off_warning,
    output logic             irq
);
    typedef struct packed {
        ahb_addr_type          ap;
        logic                  ap_valid;
        logic [31:0]           rdata;
        logic                  home_en;
        logic [8:0]            ovl_lim;
        logic [14:0]           dev_on;
        logic [14:0]           dev_off;
        logic [13:0]           tmo_lim;
        logic [3:0]            err_lim;
        logic [NCAUSE-1:0]     alarm;
        logic [NCAUSE-1:0]     irq_stat;
        logic [NCAUSE-1:0]     irq_mask;
        logic [22:0]           ovl_pre;
        logic [8:0]            ovl_cnt;
        logic [15:0]           tmo_pre;
        logic [13:0]           tmo_cnt;
        logic [3:0]            err_cnt;
        logic                  clr_prev;
        logic [23:0]           blink_cnt;
        logic                  lamp;
        logic                  fault_do;
        logic                  fault_rb;
        logic                  cur_on;
        logic                  stop;
        logic                  warn;
        logic                  irq;
        logic                  ready;
        logic                  resp;
    } mon_state_type;

    mon_state_type st;
    mon_state_type next_st;
    logic          excite;
    logic          clear_lvl;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    input_sync u_sync_excite (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (excite_pin),
        .level   (excite)
    );
    input_sync u_sync_clear (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (fault_clear_input),
        .level   (clear_lvl)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [NCAUSE-1:0] ev;
    logic              clr_edge;
    logic              wr;
    logic              rd;
    logic              energised;
    logic              any_alarm;
    logic [NCAUSE-1:0] rise;

    always_comb begin
        next_st   = st;
        ev        = '0;
        rise      = '0;
        energised = excite;
        any_alarm = |st.alarm;
        clr_edge  = st.clr_prev && !clear_lvl;
        next_st.clr_prev = clear_lvl;

        // bus address phase capture
        wr = st.ap_valid && st.ap.write;
        rd = st.ap_valid && !st.ap.write;
        next_st.ap_valid = hsel && hready && htrans[1];
        next_st.ap.addr  = haddr[7:0];
        next_st.ap.write = hwrite;

        // overload duration in 0.1 s units
        if (overload) begin
            if (st.ovl_pre == 23'(OVL_UNIT_CYC - 1)) begin
                next_st.ovl_pre = '0;
                if (st.ovl_cnt != 9'h1ff) begin
                    next_st.ovl_cnt = st.ovl_cnt + 9'h001;
                end
            end else begin
                next_st.ovl_pre = st.ovl_pre + 23'h000001;
            end
        end else begin
            next_st.ovl_pre = '0;
            next_st.ovl_cnt = '0;
        end
        ev[C_OVL] = overload && (st.ovl_cnt >= st.ovl_lim);

        ev[C_DEV_ON] = energised && (deviation > {1'b0, st.dev_on});
        ev[C_DEV_OFF] = energised && st.warn;
        // warning, not alarm, while current off
        next_st.warn = !energised && (deviation > {1'b0, st.dev_on});
        if (!energised && (deviation > {1'b0, st.dev_off})) begin
            next_st.warn = 1'b1;
        end
        ev[C_HOME] = st.home_en && op_start && !origin_set;

        if (frame_ok || st.tmo_lim == '0) begin
            next_st.tmo_pre = '0;
            next_st.tmo_cnt = '0;
        end else if (st.tmo_pre == 16'(TMO_UNIT_CYC - 1)) begin
            next_st.tmo_pre = '0;
            if (st.tmo_cnt != 14'h3fff) begin
                next_st.tmo_cnt = st.tmo_cnt + 14'h0001;
            end
        end else begin
            next_st.tmo_pre = st.tmo_pre + 16'h0001;
        end
        ev[C_TMO] = (st.tmo_lim != '0) && (st.tmo_cnt >= st.tmo_lim);

        if (frame_err && st.err_cnt != 4'hf) begin
            next_st.err_cnt = st.err_cnt + 4'h1;
        end
        ev[C_COMERR] = st.err_cnt >= st.err_lim;

        // latch until reset; clear on edge, event wins
        // timeout and error-count causes restart with their counts, so they drop here
        if (clr_edge) begin
            next_st.alarm           = ev;
            next_st.alarm[C_TMO]    = 1'b0;
            next_st.alarm[C_COMERR] = 1'b0;
            next_st.err_cnt = '0;
            next_st.tmo_cnt = '0;
        end else begin
            next_st.alarm = st.alarm | ev;
        end

        // interrupt status: new alarms set, a read clears only what it showed
        rise = next_st.alarm & ~st.alarm;
        if (rd && st.ap.addr == OFS_IRQ_STAT) begin
            next_st.irq_stat = (st.irq_stat & ~st.rdata[NCAUSE-1:0]) | rise;
        end else begin
            next_st.irq_stat = st.irq_stat | rise;
        end
        next_st.irq = |(next_st.irq_stat & st.irq_mask);

        // register writes
        if (wr) begin
            unique case (st.ap.addr)
                OFS_CTRL:     next_st.home_en  = hwdata[0];
                OFS_OVL_LIM:  next_st.ovl_lim  = hwdata[8:0];
                OFS_DEV_ON:   next_st.dev_on   = hwdata[14:0];
                OFS_DEV_OFF:  next_st.dev_off  = hwdata[14:0];
                OFS_COM_TMO:  next_st.tmo_lim  = hwdata[13:0];
                OFS_COM_ERR:  next_st.err_lim  = hwdata[3:0];
                OFS_IRQ_MASK: next_st.irq_mask = hwdata[NCAUSE-1:0];
                default:      next_st.home_en  = st.home_en;
            endcase
        end

        // register reads, data registered for the data phase
        next_st.rdata = '0;
        if (next_st.ap_valid && !hwrite) begin
            unique case (haddr[7:0])
                OFS_CTRL:     next_st.rdata = 32'(st.home_en);
                OFS_OVL_LIM:  next_st.rdata = 32'(st.ovl_lim);
                OFS_DEV_ON:   next_st.rdata = 32'(st.dev_on);
                OFS_DEV_OFF:  next_st.rdata = 32'(st.dev_off);
                OFS_COM_TMO:  next_st.rdata = 32'(st.tmo_lim);
                OFS_COM_ERR:  next_st.rdata = 32'(st.err_lim);
                OFS_ALARM:    next_st.rdata = 32'({st.warn, st.alarm});
                OFS_IRQ_STAT: next_st.rdata = 32'(st.irq_stat);
                OFS_IRQ_MASK: next_st.rdata = 32'(st.irq_mask);
                default:      next_st.rdata = '0;
            endcase
        end

        // alarm cuts current, stops motor, blinks lamp
        next_st.cur_on = energised && !(|next_st.alarm);
        next_st.stop   = |next_st.alarm;
        if (!(|next_st.alarm)) begin
            next_st.blink_cnt = '0;
            next_st.lamp      = 1'b0;
        end else if (!any_alarm || st.blink_cnt == 24'(BLINK_CYC - 1)) begin
            next_st.blink_cnt = '0;
            next_st.lamp      = !st.lamp;
        end else begin
            next_st.blink_cnt = st.blink_cnt + 24'h000001;
        end
        next_st.fault_do = !(|next_st.alarm);
        next_st.fault_rb = |next_st.alarm;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st          <= '0;
            st.ovl_lim  <= OVL_LIM_RST;
            st.dev_on   <= DEV_ON_RST;
            st.dev_off  <= DEV_OFF_RST;
            st.tmo_lim  <= COM_TMO_RST;
            st.err_lim  <= COM_ERR_RST;
            st.fault_do <= 1'b1;
            st.ready    <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hrdata                 = st.rdata;
    assign hreadyout              = st.ready;
    assign hresp                  = st.resp;
    assign fault_indicator_output = st.fault_do;
    assign fault_remote_bit       = st.fault_rb;
    assign alarm_lamp             = st.lamp;
    assign motor_current_on       = st.cur_on;
    assign motor_stop             = st.stop;
    assign dev_off_warning        = st.warn;
    assign irq                    = st.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_DIRECT_NC: assert property (@(posedge hclk) disable iff (!hresetn)
        fault_indicator_output == !fault_remote_bit)
        else $error("direct output not inverse of remote bit");
    AST_REMOTE_NO: assert property (@(posedge hclk) disable iff (!hresetn)
        fault_remote_bit == (|st.alarm))
        else $error("remote bit does not follow alarm");
    AST_CUT_CURRENT: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(fault_remote_bit) |-> !motor_current_on && motor_stop && alarm_lamp)
        else $error("alarm without cut and blink");
    AST_OVERLOAD: assert property (@(posedge hclk) disable iff (!hresetn)
        overload && st.ovl_cnt >= st.ovl_lim |=> st.alarm[C_OVL])
        else $error("overload alarm missing");
    AST_DEV_ON: assert property (@(posedge hclk) disable iff (!hresetn)
        excite && deviation > {1'b0, st.dev_on} |=> st.alarm[C_DEV_ON])
        else $error("deviation alarm missing");
    AST_WARN_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
        !excite && deviation > {1'b0, st.dev_on} |=> dev_off_warning)
        else $error("current-off warning missing");
    AST_DEV_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        excite && dev_off_warning |=> st.alarm[C_DEV_OFF])
        else $error("current-off alarm missing");
    AST_HOME_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.home_en && !st.alarm[C_HOME] && !clr_edge |=> !st.alarm[C_HOME])
        else $error("home alarm while disabled");
    AST_TMO_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        st.tmo_lim == '0 |=> st.tmo_cnt == '0)
        else $error("timeout counted while disabled");
    AST_COMERR: assert property (@(posedge hclk) disable iff (!hresetn)
        st.err_cnt >= st.err_lim && !clr_edge |=> st.alarm[C_COMERR])
        else $error("comm error alarm missing");
    AST_LATCH: assert property (@(posedge hclk) disable iff (!hresetn)
        !clr_edge |=> (st.alarm & $past(st.alarm)) == $past(st.alarm))
        else $error("alarm dropped without reset");
    AST_FRAME: assert property (@(posedge hclk) disable iff (!hresetn)
        frame_ok |=> st.tmo_cnt == '0)
        else $error("timeout not restarted");
    AST_ALARM_CUT: assert property (@(posedge hclk) disable iff (!hresetn)
        (|st.alarm) |-> !motor_current_on && motor_stop)
        else $error("current on while alarm latched");
    AST_LAMP_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|st.alarm) |-> !alarm_lamp && !motor_stop)
        else $error("lamp or stop without alarm");
    AST_ENERGISE: assert property (@(posedge hclk) disable iff (!hresetn)
        excite && !(|ev) && !(|st.alarm) |=> motor_current_on)
        else $error("current not on while excited");
    AST_HOME_ON: assert property (@(posedge hclk) disable iff (!hresetn)
        st.home_en && op_start && !origin_set |=> st.alarm[C_HOME])
        else $error("home alarm missing while enabled");
    AST_BUS_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("bus not ready or not okay");
    CV_ALARM: cover property (@(posedge hclk) disable iff (!hresetn) $rose(fault_remote_bit));
    CV_CLEAR: cover property (@(posedge hclk) disable iff (!hresetn) $fell(fault_remote_bit));
    CV_WARN:  cover property (@(posedge hclk) disable iff (!hresetn) $rose(dev_off_warning));
    CV_IRQ:   cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule : drive_alarm_monitor

// [verif/host_model.sv]
// host controller model driving the excitation and clear pins
`timescale 1ns/1ps
module host_model (
    // clock
    input  wire logic hclk,
    // pins to the driver
    output logic      excite_pin,
    output logic      fault_clear_input
);
    initial begin
        excite_pin = 1'b0;
        fault_clear_input = 1'b0;
    end
    task automatic set_excite(input logic on);
        @(posedge hclk);
        excite_pin <= on;
        // pins pass a synchroniser, so settle first
        repeat (10) @(posedge hclk);
    endtask : set_excite
    task automatic set_clear(input logic on);
        @(posedge hclk);
        fault_clear_input <= on;
        repeat (10) @(posedge hclk);
    endtask : set_clear
endmodule : host_model

// [verif/drive_alarm_monitor_tb_top.sv]
// self-checking bench of the drive alarm monitor
`timescale 1ns/1ps
module drive_alarm_monitor_tb_top
    import alarm_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        overload, op_start, origin_set, frame_ok, frame_err;
    logic [15:0] deviation;
    logic        excite_pin, fault_clear_input, irq, i1;
    logic        fault_indicator_output, fault_remote_bit, alarm_lamp;
    logic        motor_current_on, motor_stop, dev_off_warning;
    int          mismatches = 0, compares = 0, cycles = 0;

    drive_alarm_monitor i_drive_alarm_monitor (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .overload,
        .deviation, .op_start, .origin_set, .frame_ok, .frame_err,
        .excite_pin, .fault_clear_input, .fault_indicator_output,
        .fault_remote_bit, .alarm_lamp, .motor_current_on, .motor_stop,
        .dev_off_warning, .irq
    );
    host_model i_host_model (.hclk, .excite_pin, .fault_clear_input);

    // ------
    // clock, watchdog, helpers
    // ------
    always #10 hclk = ~hclk;
    // longest test waits about 80k cycles
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
        check({hreadyout, hresp}, 2'b10);
    endtask : rc
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : wait_cyc
    // 0 link error, 1 good frame, 2 positioning start
    task automatic strobe(input int k);
        @(posedge hclk);
        frame_err <= (k == 0);
        frame_ok <= (k == 1);
        op_start <= (k == 2);
        @(posedge hclk);
        frame_err <= 1'b0;
        frame_ok <= 1'b0;
        op_start <= 1'b0;
        wait_cyc(10);
    endtask : strobe
    task automatic status(input logic ovl, input logic [15:0] dev, input logic org);
        overload <= ovl;
        deviation <= dev;
        origin_set <= org;
    endtask : status
    task automatic outs(input logic a);
        check({fault_indicator_output, fault_remote_bit, motor_stop, alarm_lamp}, {~a, a, a, a});
    endtask : outs
    task automatic clear();
        i_host_model.set_clear(1'b1);
        i_host_model.set_clear(1'b0);
    endtask : clear

    // ------
    // scenarios
    // ------
    task automatic t_reset();
        rc(OFS_CTRL, 32'h0);
        rc(OFS_OVL_LIM, 32'h32);
        rc(OFS_DEV_ON, 32'h12c);
        rc(OFS_DEV_OFF, 32'h2710);
        rc(OFS_COM_TMO, 32'h0);
        rc(OFS_COM_ERR, 32'h3);
        rc(8'h24, 32'h0);
        rc(OFS_ALARM, 32'h0);
        outs(1'b0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_comerr();
        wr(OFS_COM_ERR, 32'h2);
        wr(OFS_IRQ_MASK, 32'h3f);
        strobe(0);
        rc(OFS_ALARM, 32'h0);
        strobe(0);
        rc(OFS_ALARM, 32'h20);
        outs(1'b1);
        i1 = irq;
        wr(OFS_IRQ_MASK, 32'h0);
        wait_cyc(3);
        check(i1 ^ irq, 1'b1);
        rc(OFS_IRQ_STAT, 32'h20);
        rc(OFS_IRQ_STAT, 32'h0);
        wr(OFS_IRQ_MASK, 32'h3f);
        wait_cyc(3);
        check(irq, 1'b0);
        wait_cyc(50);
        i_host_model.set_clear(1'b1);
        rc(OFS_ALARM, 32'h20);
        outs(1'b1);
        i_host_model.set_clear(1'b0);
        rc(OFS_ALARM, 32'h0);
        outs(1'b0);
        $display("test link errors done");
    endtask : t_comerr
    task automatic t_dev();
        i_host_model.set_excite(1'b1);
        check(motor_current_on, 1'b1);
        status(1'b0, 16'd300, 1'b0);
        wait_cyc(10);
        rc(OFS_ALARM, 32'h0);
        status(1'b0, 16'd301, 1'b0);
        wait_cyc(10);
        rc(OFS_ALARM, 32'h2);
        check(motor_current_on, 1'b0);
        status(1'b0, 16'd0, 1'b0);
        clear();
        rc(OFS_ALARM, 32'h0);
        i_host_model.set_excite(1'b0);
        check(motor_current_on, 1'b0);
        status(1'b0, 16'd301, 1'b0);
        wait_cyc(10);
        check(dev_off_warning, 1'b1);
        rc(OFS_ALARM, 32'h40);
        i_host_model.set_excite(1'b1);
        bus(1'b0, OFS_ALARM, 32'h0);
        check(rd & 32'h4, 32'h4);
        status(1'b0, 16'd0, 1'b0);
        clear();
        wr(OFS_DEV_OFF, 32'h7530);
        rc(OFS_DEV_OFF, 32'h7530);
        rc(OFS_DEV_ON, 32'h12c);
        $display("test deviation done");
    endtask : t_dev
    task automatic t_home();
        strobe(2);
        rc(OFS_ALARM, 32'h0);
        wr(OFS_CTRL, 32'h1);
        status(1'b0, 16'd0, 1'b1);
        strobe(2);
        rc(OFS_ALARM, 32'h0);
        status(1'b0, 16'd0, 1'b0);
        strobe(2);
        rc(OFS_ALARM, 32'h8);
        clear();
        rc(OFS_ALARM, 32'h0);
        wr(OFS_OVL_LIM, 32'h12c);
        rc(OFS_OVL_LIM, 32'h12c);
        status(1'b1, 16'd0, 1'b0);
        wait_cyc(2000);
        rc(OFS_ALARM, 32'h0);
        status(1'b0, 16'd0, 1'b0);
        $display("test home and overload done");
    endtask : t_home
    task automatic t_tmo();
        wr(OFS_COM_TMO, 32'h1);
        strobe(1);
        wait_cyc(30000);
        strobe(1);
        wait_cyc(TMO_UNIT_CYC - 2000);
        rc(OFS_ALARM, 32'h0);
        wait_cyc(4000);
        rc(OFS_ALARM, 32'h10);
        wr(OFS_COM_TMO, 32'h0);
        clear();
        rc(OFS_ALARM, 32'h0);
        $display("test link timeout done");
    endtask : t_tmo

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        overload = 1'b0;
        deviation = 16'h0;
        op_start = 1'b0;
        origin_set = 1'b0;
        frame_ok = 1'b0;
        frame_err = 1'b0;
        wait_cyc(8);
        hresetn <= 1'b1;
        t_reset();
        t_comerr();
        t_dev();
        t_home();
        t_tmo();
        give_verdict();
    end
endmodule : drive_alarm_monitor_tb_top
